/* File: logic/clc2_consts.svh */
// Constants for the second closed-loop configuration register block.
// Assumes inclusion by bare name from the design files under logic/.
//
// Operation
// RULE1: One 32-bit read/write register at 0x88, reset zero, bit 31 parity.
// RULE2: Bits 30-29 choose when the speed pulse output is active.
// RULE3: Bits 28-25 set the speed pulse divider; code zero divides by three.
// RULE4: Bit 24 enables dead-time correction of the power calculation.
// RULE5: Bits 23-21 set the back-EMF threshold, 1 to 30 mV; 6,7 invalid.
// RULE6: Bits 20-18 choose the stop method; codes 5 to 7 invalid.
// RULE7: Bits 17-14 set brake duration from 1 to 15000 ms.
// RULE8: Bits 13-11 set the stop duty threshold, immediate or 50 to 2.5 percent.
// RULE9: Bits 10-8 set the brake pin duty threshold, same encoding.
// RULE10: Bit 7 enables voltage-surge prevention.
// RULE11: Decoded fields are stable outputs; reads return last write, no side effects.
`ifndef CLC2_CONSTS_SVH
`define CLC2_CONSTS_SVH

// ==================================================
// Register map and fields
`define CFG2_OFFSET 32'h0000_0088
`define CFG2_RESET 32'h0000_0000
`define PARITY_BIT 31
`define SEL_MSB 30
`define SEL_LSB 29
`define DIV_MSB 28
`define DIV_LSB 25
`define DEADTIME_BIT 24
`define BEMF_MSB 23
`define BEMF_LSB 21
`define STOP_MSB 20
`define STOP_LSB 18
`define BRK_MSB 17
`define BRK_LSB 14
`define SDUTY_MSB 13
`define SDUTY_LSB 11
`define PDUTY_MSB 10
`define PDUTY_LSB 8
`define SURGE_BIT 7

// ==================================================
// Decoded values
`define DIV_CODE0 4'h3
`define BEMF_MV0 5'h01
`define BEMF_MV1 5'h02
`define BEMF_MV2 5'h05
`define BEMF_MV3 5'h0a
`define BEMF_MV4 5'h14
`define BEMF_MV5 5'h1e
`define STOP_LAST_VALID 3'h4
`define SEL_INVALID 2'h3

// Brake durations in milliseconds.
`define BRK_MS0 14'h0001
`define BRK_MS1 14'h0002
`define BRK_MS2 14'h0005
`define BRK_MS3 14'h000a
`define BRK_MS4 14'h000f
`define BRK_MS5 14'h0019
`define BRK_MS6 14'h0032
`define BRK_MS7 14'h004b
`define BRK_MS8 14'h0064
`define BRK_MS9 14'h00fa
`define BRK_MS10 14'h01f4
`define BRK_MS11 14'h03e8
`define BRK_MS12 14'h09c4
`define BRK_MS13 14'h1388
`define BRK_MS14 14'h2710
`define BRK_MS15 14'h3a98

// Duty thresholds in tenths of a percent; zero means immediate.
`define DUTY_PM0 10'h000
`define DUTY_PM1 10'h1f4
`define DUTY_PM2 10'h0fa
`define DUTY_PM3 10'h096
`define DUTY_PM4 10'h064
`define DUTY_PM5 10'h04b
`define DUTY_PM6 10'h032
`define DUTY_PM7 10'h019

`endif

/* File: logic/clc2_pkg.sv */
// Types shared by the closed-loop configuration block.
// Assumes the constants header is compiled alongside.
package clc2_pkg;

   // Speed pulse activity modes.
   typedef enum logic [1:0] {
      pulse_both = 2'b00,
      pulse_closed_only = 2'b01,
      pulse_open_first = 2'b10,
      pulse_none = 2'b11
   } pulse_mode_t;

   // Motor stop methods.
   typedef enum logic [2:0] {
      stop_hiz = 3'b000,
      stop_recirc = 3'b001,
      stop_low_brake = 3'b010,
      stop_high_brake = 3'b011,
      stop_spin_down = 3'b100
   } stop_method_t;

endpackage

/* File: logic/duty_threshold_decode.sv */
// Maps a three-bit duty threshold code to tenths of a percent.
// Assumes a registered consumer; purely combinational.
`timescale 1ns/1ps
`include "clc2_consts.svh"

module duty_threshold_decode
(
   input wire logic [2:0] code,
   output logic [9:0] permille
);

   // Table lookup, zero stands for an immediate stop.
   always_comb
   begin
      case (code)
         3'h0: permille = `DUTY_PM0;
         3'h1: permille = `DUTY_PM1;
         3'h2: permille = `DUTY_PM2;
         3'h3: permille = `DUTY_PM3;
         3'h4: permille = `DUTY_PM4;
         3'h5: permille = `DUTY_PM5;
         3'h6: permille = `DUTY_PM6;
         default: permille = `DUTY_PM7;
      endcase
   end

endmodule

/* File: logic/brake_time_decode.sv */
// Maps the four-bit brake time code to milliseconds.
// Assumes a registered consumer; purely combinational.
`timescale 1ns/1ps
`include "clc2_consts.svh"

module brake_time_decode
(
   input wire logic [3:0] code,
   output logic [13:0] ms
);

   // Table lookup over all sixteen codes.
   always_comb
   begin
      case (code)
         4'h0: ms = `BRK_MS0;
         4'h1: ms = `BRK_MS1;
         4'h2: ms = `BRK_MS2;
         4'h3: ms = `BRK_MS3;
         4'h4: ms = `BRK_MS4;
         4'h5: ms = `BRK_MS5;
         4'h6: ms = `BRK_MS6;
         4'h7: ms = `BRK_MS7;
         4'h8: ms = `BRK_MS8;
         4'h9: ms = `BRK_MS9;
         4'ha: ms = `BRK_MS10;
         4'hb: ms = `BRK_MS11;
         4'hc: ms = `BRK_MS12;
         4'hd: ms = `BRK_MS13;
         4'he: ms = `BRK_MS14;
         default: ms = `BRK_MS15;
      endcase
   end

endmodule

/* File: logic/closed_loop_config_two.sv */
// Second closed-loop configuration register with an AHB-Lite slave port.
// Assumes a single AHB-Lite master, word transfers only, one clock hclk.
`timescale 1ns/1ps
`include "clc2_consts.svh"

module closed_loop_config_two
   import clc2_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic config_parity,
   output logic [1:0] speed_pulse_output_select,
   output logic speed_pulse_select_valid,
   output logic [3:0] speed_pulse_divider,
   output logic dead_time_correction_enable,
   output logic [4:0] speed_pulse_backemf_threshold,
   output logic backemf_threshold_valid,
   output logic [2:0] stop_method,
   output logic stop_method_valid,
   output logic [13:0] stop_brake_duration,
   output logic [9:0] stop_duty_threshold,
   output logic [9:0] brake_pin_duty_threshold,
   output logic surge_prevention_enable
);

   // ==================================================
   // Bus address phase

   logic [31:0] cfg_r;
   logic [31:0] cfg_nxt;
   logic wr_pend_r;
   logic hit_r;
   logic [31:0] hrdata_r;
   logic [31:0] hrdata_nxt;

   // An access is taken when selected, ready and NONSEQ or SEQ.
   wire acc = hsel & hready & htrans[1];
   wire addr_hit = (haddr == `CFG2_OFFSET);
   wire rd_acc = acc & ~hwrite;
   wire wr_acc = acc & hwrite;
   // A write lands in its data phase, one cycle after the address.
   wire wr_hit = wr_pend_r & hit_r;

   // RULE1: register write path.
   assign cfg_nxt = wr_hit ? hwdata : cfg_r;

   // RULE11: read returns stored value.
   // A read right behind a write sees the new word; unmapped reads give zero.
   assign hrdata_nxt = rd_acc ? (addr_hit ? cfg_nxt : 32'h0000_0000) : hrdata_r;

   // Hold the pending write and its address match.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         hit_r <= 1'b0;
      end
      else if (hready)
      begin
         wr_pend_r <= wr_acc;
         hit_r <= addr_hit;
      end
   end

   // RULE1: storage with zero reset.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg_r <= `CFG2_RESET;
         hrdata_r <= 32'h0000_0000;
      end
      else
      begin
         cfg_r <= cfg_nxt;
         hrdata_r <= hrdata_nxt;
      end
   end

   // The slave never waits and always answers OKAY.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   assign hrdata = hrdata_r;

   // ==================================================
   // Field decode

   logic [13:0] brk_ms_w;
   logic [9:0] sduty_w;
   logic [9:0] pduty_w;
   logic [4:0] bemf_w;

   wire [1:0] sel_code = cfg_nxt[`SEL_MSB:`SEL_LSB];
   wire [3:0] div_code = cfg_nxt[`DIV_MSB:`DIV_LSB];
   wire [2:0] bemf_code = cfg_nxt[`BEMF_MSB:`BEMF_LSB];
   wire [2:0] stop_code = cfg_nxt[`STOP_MSB:`STOP_LSB];
   pulse_mode_t sel_mode;
   assign sel_mode = pulse_mode_t'(sel_code);

   // RULE2: pulse mode validity.
   wire sel_ok = (sel_mode != pulse_none);
   // RULE3: divider decode.
   wire [3:0] div_w = (div_code == 4'h0) ? `DIV_CODE0 : div_code;
   // RULE6: stop method validity.
   wire stop_ok = (stop_code <= stop_spin_down);
   // RULE5: threshold code validity.
   wire bemf_ok = (bemf_code <= 3'h5);

   // RULE5: back-EMF threshold in millivolts.
   always_comb
   begin
      case (bemf_code)
         3'h0: bemf_w = `BEMF_MV0;
         3'h1: bemf_w = `BEMF_MV1;
         3'h2: bemf_w = `BEMF_MV2;
         3'h3: bemf_w = `BEMF_MV3;
         3'h4: bemf_w = `BEMF_MV4;
         3'h5: bemf_w = `BEMF_MV5;
         default: bemf_w = 5'h00;
      endcase
   end

   // RULE7: brake time lookup.
   brake_time_decode u_brk
   (
      .code(cfg_nxt[`BRK_MSB:`BRK_LSB]),
      .ms(brk_ms_w)
   );

   // RULE8: stop duty lookup.
   duty_threshold_decode u_sduty
   (
      .code(cfg_nxt[`SDUTY_MSB:`SDUTY_LSB]),
      .permille(sduty_w)
   );

   // RULE9: brake pin duty lookup.
   duty_threshold_decode u_pduty
   (
      .code(cfg_nxt[`PDUTY_MSB:`PDUTY_LSB]),
      .permille(pduty_w)
   );

   // ==================================================
   // Decoded outputs

   // RULE11: registered stable settings.
   // Reset values are the decode of an all-zero register.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         config_parity <= 1'b0;
         speed_pulse_output_select <= 2'h0;
         speed_pulse_select_valid <= 1'b1;
         speed_pulse_divider <= `DIV_CODE0;
         dead_time_correction_enable <= 1'b0;
         speed_pulse_backemf_threshold <= `BEMF_MV0;
         backemf_threshold_valid <= 1'b1;
         stop_method <= 3'h0;
         stop_method_valid <= 1'b1;
         stop_brake_duration <= `BRK_MS0;
         stop_duty_threshold <= `DUTY_PM0;
         brake_pin_duty_threshold <= `DUTY_PM0;
         surge_prevention_enable <= 1'b0;
      end
      else
      begin
         config_parity <= cfg_nxt[`PARITY_BIT];
         speed_pulse_output_select <= sel_code;
         speed_pulse_select_valid <= sel_ok;
         speed_pulse_divider <= div_w;
         // RULE4: dead-time correction enable.
         dead_time_correction_enable <= cfg_nxt[`DEADTIME_BIT];
         speed_pulse_backemf_threshold <= bemf_w;
         backemf_threshold_valid <= bemf_ok;
         stop_method <= stop_code;
         stop_method_valid <= stop_ok;
         stop_brake_duration <= brk_ms_w;
         stop_duty_threshold <= sduty_w;
         brake_pin_duty_threshold <= pduty_w;
         // RULE10: surge prevention enable.
         surge_prevention_enable <= cfg_nxt[`SURGE_BIT];
      end
   end

   // ==================================================
   // Checks

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // A data-phase write to the register stores the bus word.
   a_write_stores_word: assert property (wr_hit |=> cfg_r == $past(hwdata)) // RULE1
      else $error("register did not take written word");

   // Without a write the stored word never moves.
   a_no_write_hold: assert property (!wr_hit |=> $stable(cfg_r)) // RULE11
      else $error("register changed without a write");

   // A mapped read returns the stored word one cycle later.
   a_read_returns_cfg: assert property (rd_acc && addr_hit && !wr_hit |=> hrdata == $past(cfg_r)) // RULE11
      else $error("read data differs from stored word");

   // Read directly after a write returns the new word.
   a_read_after_write: assert property (rd_acc && addr_hit && wr_hit |=> hrdata == $past(hwdata)) // RULE11
      else $error("read after write returned stale data");

   // Unmapped reads answer zero.
   a_unmapped_read_zero: assert property (rd_acc && !addr_hit |=> hrdata == 32'h0000_0000) // RULE1
      else $error("unmapped read not zero");

   // Slave answers at once with OKAY.
   a_bus_okay_ready: assert property (hreadyout && !hresp)
      else $error("slave stalled or answered error");

   // Mode select validity follows the stored bits.
   a_select_decode: assert property (##1 speed_pulse_select_valid == (cfg_r[`SEL_MSB:`SEL_LSB] != `SEL_INVALID)) // RULE2
      else $error("pulse mode validity wrong");

   // Divider code zero gives three, otherwise the code itself.
   a_divider_decode: assert property (##1 speed_pulse_divider == ((cfg_r[`DIV_MSB:`DIV_LSB] == 4'h0) // RULE3
      ? `DIV_CODE0 : cfg_r[`DIV_MSB:`DIV_LSB]))
      else $error("divider decode wrong");

   // Dead-time enable tracks its bit after a write.
   a_deadtime_follow: assert property (wr_hit |=> dead_time_correction_enable == $past(hwdata[`DEADTIME_BIT])) // RULE4
      else $error("dead-time enable did not follow write");

   // Top back-EMF code gives 30 mV and is flagged valid.
   a_bemf_top_code: assert property (cfg_r[`BEMF_MSB:`BEMF_LSB] == 3'h5 && $stable(cfg_r) // RULE5
      |-> speed_pulse_backemf_threshold == `BEMF_MV5 && backemf_threshold_valid)
      else $error("back-EMF threshold decode wrong");

   // Stop methods above active spin down are flagged invalid.
   a_stop_validity: assert property (##1 stop_method_valid == (cfg_r[`STOP_MSB:`STOP_LSB] <= `STOP_LAST_VALID)) // RULE6
      else $error("stop method validity wrong");

   // Longest brake code yields 15000 ms.
   a_brake_longest: assert property (wr_hit && hwdata[`BRK_MSB:`BRK_LSB] == 4'hf // RULE7
      |=> stop_brake_duration == `BRK_MS15)
      else $error("brake duration decode wrong");

   // Writing stop duty code one gives 50 percent.
   a_stop_duty_map: assert property (wr_hit && hwdata[`SDUTY_MSB:`SDUTY_LSB] == 3'h1 // RULE8
      |=> stop_duty_threshold == `DUTY_PM1)
      else $error("stop duty threshold decode wrong");

   // Brake pin duty code seven is 2.5 percent.
   a_pin_duty_map: assert property (wr_hit && hwdata[`PDUTY_MSB:`PDUTY_LSB] == 3'h7 // RULE9
      |=> brake_pin_duty_threshold == `DUTY_PM7)
      else $error("brake pin duty threshold decode wrong");

   // Surge prevention follows its bit, held while the register stands.
   a_surge_follow: assert property (##1 surge_prevention_enable == cfg_r[`SURGE_BIT]) // RULE10
      else $error("surge prevention enable wrong");

   // Surge prevention moves with a write at its data-phase edge.
   a_surge_write: assert property (wr_hit |=> surge_prevention_enable == $past(hwdata[`SURGE_BIT])) // RULE10
      else $error("surge prevention enable did not follow write");

   // The parity bit is stored and shown as written.
   a_parity_follow: assert property (##1 config_parity == cfg_r[`PARITY_BIT]) // RULE1
      else $error("parity output wrong");

   // A write moves the parity output at its data-phase edge.
   a_parity_write: assert property (wr_hit |=> config_parity == $past(hwdata[`PARITY_BIT])) // RULE1
      else $error("parity output did not follow write");

   // The select code passes through unchanged.
   a_select_pass: assert property (##1 speed_pulse_output_select == cfg_r[`SEL_MSB:`SEL_LSB]) // RULE2
      else $error("pulse mode select wrong");

   // Closed loop only is a valid mode.
   a_select_closed_valid: assert property (cfg_r[`SEL_MSB:`SEL_LSB] == 2'h1 |-> speed_pulse_select_valid) // RULE2
      else $error("closed loop mode flagged invalid");

   // Dead-time enable holds its bit while the register stands.
   a_deadtime_hold: assert property (##1 dead_time_correction_enable == cfg_r[`DEADTIME_BIT]) // RULE4
      else $error("dead-time enable wrong");

   // Threshold codes up to five are valid.
   a_bemf_valid_flag: assert property (##1 backemf_threshold_valid == (cfg_r[`BEMF_MSB:`BEMF_LSB] <= 3'h5)) // RULE5
      else $error("back-EMF validity wrong");

   // Invalid threshold codes show zero millivolts.
   a_bemf_invalid_zero: assert property (!backemf_threshold_valid |-> speed_pulse_backemf_threshold == 5'h00) // RULE5
      else $error("invalid back-EMF code not zero");

   // The lowest threshold code gives 1 mV.
   a_bemf_low_code: assert property (cfg_r[`BEMF_MSB:`BEMF_LSB] == 3'h0 |-> speed_pulse_backemf_threshold == `BEMF_MV0) // RULE5
      else $error("lowest back-EMF threshold wrong");

   // The stop code passes through unchanged.
   a_stop_method_pass: assert property (##1 stop_method == cfg_r[`STOP_MSB:`STOP_LSB]) // RULE6
      else $error("stop method wrong");

   // Active spin down is the last valid method.
   a_stop_spin_valid: assert property (cfg_r[`STOP_MSB:`STOP_LSB] == `STOP_LAST_VALID |-> stop_method_valid) // RULE6
      else $error("active spin down flagged invalid");

   // Brake code zero gives 1 ms.
   a_brake_shortest: assert property (cfg_r[`BRK_MSB:`BRK_LSB] == 4'h0 |-> stop_brake_duration == `BRK_MS0) // RULE7
      else $error("shortest brake duration wrong");

   // Brake code eight gives 100 ms.
   a_brake_mid_code: assert property (cfg_r[`BRK_MSB:`BRK_LSB] == 4'h8 |-> stop_brake_duration == `BRK_MS8) // RULE7
      else $error("middle brake duration wrong");

   // Stop duty code zero acts at once.
   a_stop_duty_now: assert property (cfg_r[`SDUTY_MSB:`SDUTY_LSB] == 3'h0 |-> stop_duty_threshold == `DUTY_PM0) // RULE8
      else $error("immediate stop duty wrong");

   // Brake pin duty code one is 50 percent.
   a_pin_duty_half: assert property (cfg_r[`PDUTY_MSB:`PDUTY_LSB] == 3'h1 |-> brake_pin_duty_threshold == `DUTY_PM1) // RULE9
      else $error("brake pin half duty wrong");

   // Read data holds until the next read is taken.
   a_hrdata_hold: assert property (!rd_acc |=> $stable(hrdata)) // RULE11
      else $error("read data changed without a read");

endmodule

/* File: sim/test_closed_loop_config_two.sv */
// Self-checking testbench for the second closed-loop configuration register.
// Assumes the design files under logic/ and the package clc2_pkg are compiled first.
`timescale 1ns/1ps

module test_closed_loop_config_two
   import clc2_pkg::*;
;
   // ==================================================
   // Signals and expected decode tables
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout, hresp, config_parity, speed_pulse_select_valid;
   logic dead_time_correction_enable, backemf_threshold_valid, stop_method_valid, surge_prevention_enable;
   logic [31:0] hrdata;
   logic [1:0] speed_pulse_output_select;
   logic [3:0] speed_pulse_divider;
   logic [4:0] speed_pulse_backemf_threshold;
   logic [2:0] stop_method;
   logic [13:0] stop_brake_duration;
   logic [9:0] stop_duty_threshold, brake_pin_duty_threshold;
   int failures = 0;
   int tests_run = 0;
   logic [31:0] rd;
   logic [31:0] w;
   logic [3:0] i;
   localparam logic [13:0] brk_ms [16] = '{14'h0001, 14'h0002, 14'h0005, 14'h000a, 14'h000f, 14'h0019,
      14'h0032, 14'h004b, 14'h0064, 14'h00fa, 14'h01f4, 14'h03e8, 14'h09c4, 14'h1388, 14'h2710, 14'h3a98};
   localparam logic [9:0] duty_pm [8] = '{10'h000, 10'h1f4, 10'h0fa, 10'h096, 10'h064, 10'h04b, 10'h032, 10'h019};
   localparam logic [4:0] bemf_mv [8] = '{5'h01, 5'h02, 5'h05, 5'h0a, 5'h14, 5'h1e, 5'h00, 5'h00};

   // The clock toggles every 20 ns, half of its 40 ns period.
   always #20 hclk = ~hclk;

   // The bus ready input follows the slave's own ready, as with one slave.
   closed_loop_config_two dut
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .config_parity(config_parity), .speed_pulse_output_select(speed_pulse_output_select),
      .speed_pulse_select_valid(speed_pulse_select_valid), .speed_pulse_divider(speed_pulse_divider),
      .dead_time_correction_enable(dead_time_correction_enable),
      .speed_pulse_backemf_threshold(speed_pulse_backemf_threshold),
      .backemf_threshold_valid(backemf_threshold_valid), .stop_method(stop_method),
      .stop_method_valid(stop_method_valid), .stop_brake_duration(stop_brake_duration),
      .stop_duty_threshold(stop_duty_threshold), .brake_pin_duty_threshold(brake_pin_duty_threshold),
      .surge_prevention_enable(surge_prevention_enable)
   );

   // ==================================================
   // Reporting tasks
   task automatic stop_test();
      $display("counts: %0d compares, %0d mismatches", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // ==================================================
   // Bus tasks, entered just after a rising edge
   task automatic wait_rdy();
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1)
      begin
         chk(hreadyout, 32'h0000_0001);
         stop_test();
      end
   endtask

   task automatic ahb_wr(input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= 1'b1;
      htrans <= 2'h2;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask

   task automatic ahb_rd(input logic [31:0] a, output logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= 1'b0;
      htrans <= 2'h2;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      wait_rdy();
      d = hrdata;
      chk(hresp, 1'b0);
   endtask

   // Compares every decoded output against the decode of a stored word.
   task automatic chk_all(input logic [31:0] v);
      #1;
      chk(config_parity, v[31]);
      chk(speed_pulse_output_select, v[30:29]);
      chk(speed_pulse_select_valid, v[30:29] != 2'h3);
      chk(speed_pulse_divider, (v[28:25] == 4'h0) ? 4'h3 : v[28:25]);
      chk(dead_time_correction_enable, v[24]);
      chk(speed_pulse_backemf_threshold, bemf_mv[v[23:21]]);
      chk(backemf_threshold_valid, v[23:21] <= 3'h5);
      chk(stop_method, v[20:18]);
      chk(stop_method_valid, v[20:18] <= 3'h4);
      chk(stop_brake_duration, brk_ms[v[17:14]]);
      chk(stop_duty_threshold, duty_pm[v[13:11]]);
      chk(brake_pin_duty_threshold, duty_pm[v[10:8]]);
      chk(surge_prevention_enable, v[7]);
      // Realign with a rising edge so the next request starts on it.
      @(posedge hclk);
   endtask

   // ==================================================
   // Main sequence
   initial
   begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset value and its decode.
      chk_all(32'h0000_0000);
      @(posedge hclk);
      ahb_rd(32'h0000_0088, rd);
      chk(rd, 32'h0000_0000);
      $display("test reset values done");
      // Rows: each row sets every field to a code derived from the row index, checks the decode, then reads the word back.
      for (int k = 0; k < 16; k++)
      begin
         i = 4'(k);
         w = {i[0], i[1:0], i, i[1], i[2:0], i[2:0] + 3'h3, ~i, i[2:0], ~i[2:0], i[0] ^ i[1], 7'(k * 5)};
         ahb_wr(32'h0000_0088, w);
         chk_all(w);
         ahb_rd(32'h0000_0088, rd);
         chk(rd, w);
      end
      $display("test field rows done");
      // Reads leave the stored word and its decode untouched.
      ahb_rd(32'h0000_0088, rd);
      chk_all(w);
      chk(rd, w);
      $display("test read side effects done");
      // Unmapped writes are dropped and unmapped reads give zero.
      ahb_wr(32'h0000_008c, 32'hffff_ffff);
      ahb_wr(32'h0000_0084, 32'hffff_ffff);
      chk_all(w);
      ahb_rd(32'h0000_008c, rd);
      chk(rd, 32'h0000_0000);
      ahb_rd(32'h0000_0088, rd);
      chk(rd, w);
      $display("test unmapped addresses done");
      // All ones, including the parity bit and invalid codes, then a reset in mid-run.
      ahb_wr(32'h0000_0088, 32'hffff_ffff);
      chk_all(32'hffff_ffff);
      ahb_rd(32'h0000_0088, rd);
      chk(rd, 32'hffff_ffff);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      chk_all(32'h0000_0000);
      chk(hrdata, 32'h0000_0000);
      @(posedge hclk);
      ahb_rd(32'h0000_0088, rd);
      chk(rd, 32'h0000_0000);
      $display("test mid-run reset done");
      stop_test();
   end
endmodule
